// ===== pcr_pkg.sv
// Package for the clock synthesizer configuration register bank
package pcr_pkg;
  localparam int unsigned NUM_BYTES     = 8;
  localparam logic [2:0]  OFS_REF_LO    = 3'h0;
  localparam logic [2:0]  OFS_REF_HI    = 3'h1;
  localparam logic [2:0]  OFS_POST      = 3'h2;
  localparam logic [2:0]  OFS_FBK_LO    = 3'h3;
  localparam logic [2:0]  OFS_FBK_HI    = 3'h4;
  localparam logic [2:0]  OFS_LOOP      = 3'h5;
  localparam logic [2:0]  OFS_PWR_SYNC  = 3'h6;
  localparam logic [2:0]  OFS_RSVD      = 3'h7;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  // Flat bit positions across the 64-bit map
  localparam int unsigned BIT_REF_SRC   = 12;
  localparam int unsigned BIT_PD_FIRST  = 13;
  localparam int unsigned BIT_FBK_SRC   = 38;
  localparam int unsigned BIT_OUT_MODE  = 39;
  localparam int unsigned BIT_PUMP_LO   = 40;
  localparam int unsigned BIT_RES_LO    = 44;
  localparam int unsigned BIT_CAP       = 46;
  localparam int unsigned BIT_ALIGN_EN  = 48;
  localparam int unsigned BIT_ALIGN_POL = 49;
  localparam int unsigned BIT_PD_SECOND = 53;
  localparam int unsigned BIT_REF_LO    = 0;
  localparam int unsigned BIT_FBK_LO    = 24;
  localparam int unsigned BIT_STAGE1_LO = 16;
  localparam int unsigned BIT_STAGE2_LO = 20;
  localparam int unsigned BIT_STAGE3_LO = 14;
  localparam logic [3:0]  POST_CODE_MAX = 4'hb;

  typedef struct packed {
    logic [11:0] reference_divider_value;
    logic [13:0] feedback_divider_value;
    logic [3:0]  post_stage_first_mod;
    logic [3:0]  post_stage_second_mod;
    logic [3:0]  post_stage_third_mod;
    logic        post_code_illegal;
    logic        reference_input_select;
    logic        feedback_input_select;
    logic        power_down_first;
    logic        power_down_second;
    logic        output_mode_cmos;
    logic [1:0]  pump_current_sel;
    logic [1:0]  loop_resistor_sel;
    logic        loop_capacitor_sel;
    logic        align_input_enable;
    logic        align_edge_polarity;
  } pcr_cfg_s;
endpackage : pcr_pkg

// ===== pcr_regs.sv
// Configuration register bank with decoded control outputs
//
// How it works
// RQ1 - Bit 12 picks crystal or pin reference
// RQ2 - Bit 38 picks oscillator or post feedback
// RQ3 - Bits 13, 53 are independent power-downs
// RQ4 - Bit 39 picks differential or CMOS output
// RQ5 - Pump, resistor, capacitor trims exposed statically
// RQ6 - Bit 48 enables acting on align pin
// RQ7 - Bit 49 chooses falling or rising edge
// RQ8 - Reference divider from bits 11 to 0
// RQ9 - Feedback divider from bits 37 to 24
// RQ10 - Post codes are modulus minus one, 0-11
// RQ11 - Third post code gives 1,2,4,8
// RQ12 - Reset clears all; readback equals written
// RQ13 - Host writes zero to reserved bits
// RQ14 - Whole byte updates at once
module pcr_regs
  import pcr_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       wr_strobe,
  input  wire logic [2:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [2:0] rd_addr,
  output logic      [7:0] rd_data,
  input  wire logic       align_pin,
  output logic            align_event,
  output pcr_cfg_s        cfg
);

  logic [7:0]  regs      [NUM_BYTES];
  logic [7:0]  next_regs [NUM_BYTES];
  logic [63:0] flat;
  logic        align_last;
  logic        next_align_last;
  logic        next_align_event;
  logic [7:0]  next_rd_data;

  // Modulus of third stage is 1 shifted by code
  function automatic logic [3:0] post_stage_third_mod_modulus(input logic [1:0] code);
    post_stage_third_mod_modulus = 4'h1 << code; // [RQ11]
  endfunction : post_stage_third_mod_modulus

  always_comb begin
    for (int i = 0; i < NUM_BYTES; i++) begin
      next_regs[i] = regs[i];
    end
    if (wr_strobe) begin
      next_regs[wr_addr] = wr_data; // [RQ14]
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_BYTES; i++) begin
      if (!resetn) begin
        regs[i] <= BYTE_RESET; // [RQ12]
      end else begin
        regs[i] <= next_regs[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_BYTES; i++) begin
      flat[i*8 +: 8] = regs[i];
    end
  end

  always_comb begin
    next_rd_data = regs[rd_addr]; // [RQ12]
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_data <= BYTE_RESET;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  always_comb begin
    cfg.reference_divider_value = flat[BIT_REF_LO +: 12];    // [RQ8]
    cfg.feedback_divider_value  = flat[BIT_FBK_LO +: 14];    // [RQ9]
    cfg.post_stage_first_mod    = flat[BIT_STAGE1_LO +: 4];  // [RQ10]
    cfg.post_stage_second_mod   = flat[BIT_STAGE2_LO +: 4];  // [RQ10]
    cfg.post_code_illegal       = (flat[BIT_STAGE1_LO +: 4] > POST_CODE_MAX)
                                | (flat[BIT_STAGE2_LO +: 4] > POST_CODE_MAX); // [RQ10]
    cfg.post_stage_third_mod    = post_stage_third_mod_modulus(flat[BIT_STAGE3_LO +: 2]); // [RQ11]
    cfg.reference_input_select  = flat[BIT_REF_SRC];         // [RQ1]
    cfg.feedback_input_select   = flat[BIT_FBK_SRC];         // [RQ2]
    cfg.power_down_first        = flat[BIT_PD_FIRST];        // [RQ3]
    cfg.power_down_second       = flat[BIT_PD_SECOND];       // [RQ3]
    cfg.output_mode_cmos        = flat[BIT_OUT_MODE];        // [RQ4]
    cfg.pump_current_sel        = flat[BIT_PUMP_LO +: 2];    // [RQ5]
    cfg.loop_resistor_sel       = flat[BIT_RES_LO +: 2];     // [RQ5]
    cfg.loop_capacitor_sel      = flat[BIT_CAP];             // [RQ5]
    cfg.align_input_enable      = flat[BIT_ALIGN_EN];        // [RQ6]
    cfg.align_edge_polarity     = flat[BIT_ALIGN_POL];       // [RQ7]
  end

  // Align edge detect, one-cycle pulse
  always_comb begin
    next_align_last  = align_pin;
    next_align_event = 1'b0;
    if (flat[BIT_ALIGN_EN]) begin // [RQ6]
      if (flat[BIT_ALIGN_POL]) begin
        next_align_event = align_pin & ~align_last; // [RQ7]
      end else begin
        next_align_event = ~align_pin & align_last; // [RQ7]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      align_last  <= 1'b0;
      align_event <= 1'b0;
    end else begin
      align_last  <= next_align_last;
      align_event <= next_align_event;
    end
  end

endmodule : pcr_regs

// ===== pcr_regs_sva.sv
// Checker of the register bank ports
module pcr_sva import pcr_pkg::*; (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic       wr_strobe,
  input wire logic [2:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic       align_pin,
  input wire logic       align_event,
  input wire pcr_cfg_s   cfg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_rs; wr_strobe&&wr_addr==1|=>cfg.reference_input_select==$past(wr_data[4]); endproperty
  a_rs: assert property (p_rs) else $error("ref src");
  property p_fs; wr_strobe&&wr_addr==4|=>cfg.feedback_input_select==$past(wr_data[6]); endproperty
  a_fs: assert property (p_fs) else $error("fbk src");
  property p_pd; wr_strobe&&wr_addr==6|=>cfg.power_down_second==$past(wr_data[5]); endproperty
  a_pd: assert property (p_pd) else $error("pd");
  property p_md; wr_strobe&&wr_addr==4|=>cfg.output_mode_cmos==$past(wr_data[7]); endproperty
  a_md: assert property (p_md) else $error("mode");
  property p_en; !cfg.align_input_enable|=>!align_event; endproperty
  a_en: assert property (p_en) else $error("align off");
  property p_pl; cfg.align_input_enable&&(cfg.align_edge_polarity?$rose(align_pin):$fell(align_pin))|=>align_event;
  endproperty
  a_pl: assert property (p_pl) else $error("align edge");
  property p_po; wr_strobe&&wr_addr==2|=>cfg.post_code_illegal==($past(wr_data[3:0])>11||$past(wr_data[7:4])>11);
  endproperty
  a_po: assert property (p_po) else $error("post");
  property p_p3; wr_strobe&&wr_addr==1|=>cfg.post_stage_third_mod==4'h1<<$past(wr_data[7:6]); endproperty
  a_p3: assert property (p_p3) else $error("mod3");
  cover property (align_event);
  cover property (cfg.post_code_illegal);
  cover property (wr_strobe&&wr_addr==7);
endmodule : pcr_sva
bind pcr_regs pcr_sva u_sva (.*);

// ===== pcr_host.sv
// Host byte access model
module pcr_host (
  input  wire logic       mclk,
  output logic            wr_strobe = 1'b0,
  output logic      [2:0] wr_addr = 3'h0,
  output logic      [7:0] wr_data = 8'h00,
  output logic      [2:0] rd_addr = 3'h0
);
  task automatic xfer(input logic en, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr_strobe <= en;
    wr_addr   <= a;
    wr_data   <= d;
    rd_addr   <= a;
  endtask : xfer
endmodule : pcr_host

// ===== tb_pcr_regs.sv
// Testbench of the register bank
module tb_pcr_regs import pcr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        align_pin = 1'b0;
  logic        wr_strobe, align_event;
  logic [2:0]  wr_addr, rd_addr;
  logic [7:0]  wr_data, rd_data;
  pcr_cfg_s    cfg;
  logic [7:0]  cnt;
  int          bad_count = 0;
  int          n_checks = 0;
  logic [10:0] rows [10] = '{11'h0a5, 11'h1df, 11'h2ba, 11'h35a, 11'h4ff, 11'h573, 11'h623, 11'h700, 11'h16f, 11'h2b0};
  pcr_regs u_dut (.*);
  pcr_host u_host (.*);
  task automatic chk(input string n, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_w(input string n, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_w
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic put(input logic [10:0] r);
    u_host.xfer(1'b1, r[10:8], r[7:0]);
    u_host.xfer(1'b0, r[10:8], 8'h00);
  endtask : put
  task automatic pin(input logic v);
    @(posedge mclk);
    align_pin <= v;
    cnt = 8'h00;
    repeat (4) begin
      @(posedge mclk);
      #1;
      cnt += 8'(align_event);
    end
  endtask : pin
  initial forever #25 mclk = ~mclk;
  initial begin
    #20000;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      put(rows[i]);
      @(posedge mclk);
      #1;
      chk("rd_data", rows[i][7:0], rd_data);
    end
    chk_w("ref_div", 16'h0fa5, 16'(cfg.reference_divider_value));
    chk_w("fbk_div", 16'h3f5a, 16'(cfg.feedback_divider_value));
    chk_w("post12", 16'h00b0, 16'({cfg.post_stage_second_mod, cfg.post_stage_first_mod}));
    chk_w("post_stage_third_mod", 16'h0002, 16'(cfg.post_stage_third_mod));
    chk_w("srcs", 16'h000f, 16'({cfg.reference_input_select, cfg.feedback_input_select, cfg.power_down_first, cfg.power_down_second, cfg.output_mode_cmos}));
    chk_w("trims", 16'h001f, 16'({cfg.pump_current_sel, cfg.loop_resistor_sel, cfg.loop_capacitor_sel}));
    pin(1'b1);
    chk("rise", 8'h01, cnt);
    pin(1'b0);
    chk("fall", 8'h00, cnt);
    put(11'h621);
    pin(1'b1);
    chk("rise", 8'h00, cnt);
    pin(1'b0);
    chk("fall", 8'h01, cnt);
    put(11'h602);
    pin(1'b1);
    chk("off", 8'h00, cnt);
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    chk("rd_reset", 8'h00, rd_data);
    chk_w("cfg_reset", 16'h0000, 16'(cfg.feedback_divider_value));
    test_done;
  end
endmodule : tb_pcr_regs
